// File: shared/level_monitor_pkg.sv
// level_monitor_pkg: register map, field layout, reset values and timing counts
// assumes a 20 MHz hclk and an AHB-Lite register bus with 32-bit data
package level_monitor_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TICK_PERIOD_S   = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;
    localparam int unsigned SHORT_PERIOD_S  = 900;     // 15 min
    localparam int unsigned LONG_PERIOD_S   = 86_400;  // 24 h
    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_RX_THR     = 8'h04;
    localparam logic [7:0] OFS_TX_THR     = 8'h08;
    localparam logic [7:0] OFS_LEVELS     = 8'h0C;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h14;
    localparam logic [7:0] OFS_INT_CLEAR  = 8'h18;
    localparam logic [7:0] OFS_SELECTED   = 8'h1C;
    localparam logic [7:0] OFS_RX_EXT     = 8'h20;
    localparam logic [7:0] OFS_TX_EXT     = 8'h24;
    localparam logic [7:0] OFS_CNT_BASE   = 8'h40;     // 16 counter words
    // counter word index: [3:2] bank, [1:0] counter
    localparam logic [1:0] BANK_SHORT_CUR  = 2'h0;
    localparam logic [1:0] BANK_SHORT_HIST = 2'h1;
    localparam logic [1:0] BANK_LONG_CUR   = 2'h2;
    localparam logic [1:0] BANK_LONG_HIST  = 2'h3;
    // ************************************************************
    // control fields
    // ************************************************************
    localparam int unsigned CTRL_CLR_ON_THR = 0;   // clear both rx or both tx counters when either threshold of that pair changes
    localparam int unsigned CTRL_TX_PRESENT = 1;   // transmitted level primitive fitted
    localparam int unsigned CTRL_TX_OFFSET  = 2;   // tx level as nominal plus offset
    localparam int unsigned CTRL_PROT_D     = 3;   // protection scheme type D
    localparam int unsigned CTRL_RX_SEL     = 4;   // selected rx counter to forward
    localparam int unsigned CTRL_EXT_EN     = 5;   // extreme recorders enabled
    localparam logic [7:0]  CTRL_RESET      = 8'h22;
    localparam logic [7:0]  RX_THR0_RESET   = 8'hB0;   // -80 dBm
    localparam logic [7:0]  RX_THR1_RESET   = 8'hBA;   // -70 dBm
    localparam logic [7:0]  TX_THR0_RESET   = 8'h1E;   // 30
    localparam logic [7:0]  TX_THR1_RESET   = 8'h23;   // 35
    // interrupt status bits
    localparam int unsigned INT_SECOND = 0;
    localparam int unsigned INT_SHORT  = 1;
    localparam int unsigned INT_LONG   = 2;
    localparam int unsigned INT_RX_LOW = 3;
    localparam int unsigned INT_TX_HI  = 4;
    localparam int unsigned INT_BITS   = 5;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

// File: verilog/radio_level_performance_monitor.sv
// radio_level_performance_monitor: threshold-second counters and extremes for rx/tx level
// assumes levels come from estimators on hclk, already integer and stable per second
//
// Behaviour
// - count a second whenever received level stayed below the selected threshold
// - rx thresholds held in dBm, writable by management over the bus
// - two rx low-level-second counters with distinct thresholds
// - forward only one selected rx low-level-second count to management
// - every rx counter readable on management request
// - threshold change either clears both counters of its rx or tx pair or leaves them, software chooses
// - rx peak and floor reloaded with present level at period start
// - each second rx peak raised and floor lowered by present level
// - count a second whenever transmitted level exceeded the selected threshold
// - tx threshold in dBm absolute or dB offset, writable over the bus
// - tx counters active only when the transmitted level primitive exists
// - tx counters readable on request when the tx primitive exists
// - tx peak and floor, only with tx primitive, reloaded at period start
// - each second tx peak raised and floor lowered by present level
// - quality information forwarded only under type D protection
// - received level presented as integer dBm
// - tx level as absolute dBm or nominal dBm plus offset dB
// - counters kept in current and history banks for 15 min and 24 h
`timescale 1ns/1ps
`default_nettype none
module radio_level_performance_monitor #(
    parameter int unsigned TICK_CYCLES_P = level_monitor_pkg::TICK_CYCLES,
    parameter int unsigned SHORT_SECS_P  = level_monitor_pkg::SHORT_PERIOD_S,
    parameter int unsigned LONG_SECS_P   = level_monitor_pkg::LONG_PERIOD_S
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // level estimators, signed integers
    input  wire logic [7:0]  received_level,
    input  wire logic [7:0]  transmitted_level,
    input  wire logic [7:0]  tx_offset,
    input  wire logic [15:0] quality_errors,
    // management side
    output logic      [15:0] rx_low_level_seconds,
    output logic      [15:0] quality_report,
    output logic             quality_valid,
    output logic             second_tick,
    output logic             irq
);
    import level_monitor_pkg::*;

    typedef struct packed {
        logic [24:0]      tick_cnt;
        logic [16:0]      sec_cnt;
        logic [9:0]       short_sec;
        logic             short_strobe;
        logic             long_strobe;
        logic             tick;
        logic [7:0]       ctrl;
        logic [1:0][7:0]  rx_thr;
        logic [1:0][7:0]  tx_thr;
        logic [1:0]       rx_below;   // level stayed below all second
        logic [1:0]       tx_above;   // level stayed above all second
        logic [15:0][15:0] cnt;       // [bank*4 + counter]
        logic [7:0]       rx_peak;
        logic [7:0]       rx_floor;
        logic [7:0]       tx_peak;
        logic [7:0]       tx_floor;
        logic [INT_BITS-1:0] int_status;
        logic [INT_BITS-1:0] int_enable;
        logic             dp_write;
        logic [7:0]       dp_addr;
        logic [31:0]      rdata;
        logic [15:0]      quality;
        logic             quality_v;
    } state_t;

    state_t s;
    state_t n;
    logic   sel_write;
    logic   sel_read;
    logic [7:0]  eff_tx;
    logic [31:0] rd_word;

    // signed compare helper shared by the thresholds and extremes
    function automatic logic lt_s(input logic [7:0] a, input logic [7:0] b);
        lt_s = $signed(a) < $signed(b);
    endfunction

    // counter increment that saturates instead of wrapping
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    // ************************************************************
    // bus decode
    // ************************************************************
    // zero-wait slave, so any valid selected transfer is taken at once
    assign sel_write = hsel && hready && htrans[1] && hwrite;
    assign sel_read  = hsel && hready && htrans[1] && !hwrite;
    // tx level: nominal plus offset when that form is fitted
    assign eff_tx = s.ctrl[CTRL_TX_OFFSET] ? 8'(transmitted_level + tx_offset) : transmitted_level;

    // read mux, evaluated in the address phase and registered
    always_comb begin
        logic [3:0] idx;
        idx     = haddr[5:2];
        rd_word = 32'h0000_0000;
        if (haddr[7:6] == 2'h1) begin
            // tx counters read as zero without the tx primitive
            if (idx[1] && !s.ctrl[CTRL_TX_PRESENT]) begin
                rd_word = 32'h0000_0000;
            end else begin
                rd_word = {16'h0000, s.cnt[idx]};
            end
        end else begin
            case (haddr[7:0])
                OFS_CTRL:       rd_word = {24'h00_0000, s.ctrl};
                OFS_RX_THR:     rd_word = {16'h0000, s.rx_thr[1], s.rx_thr[0]};
                OFS_TX_THR:     rd_word = {16'h0000, s.tx_thr[1], s.tx_thr[0]};
                OFS_LEVELS:     rd_word = {16'h0000, eff_tx, received_level};
                OFS_INT_STATUS: rd_word = {27'h000_0000, s.int_status};
                OFS_INT_ENABLE: rd_word = {27'h000_0000, s.int_enable};
                OFS_SELECTED:   rd_word = {16'h0000, rx_low_level_seconds};
                OFS_RX_EXT:     rd_word = {16'h0000, s.rx_peak, s.rx_floor};
                OFS_TX_EXT:     rd_word = {16'h0000, s.tx_peak, s.tx_floor};
                default:        rd_word = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [INT_BITS-1:0] ev;
        logic [INT_BITS-1:0] clr;
        logic                tx_on;
        logic                ext_on;
        logic [1:0]          thr_clr;
        n       = s;
        ev      = '0;
        clr     = '0;
        thr_clr = '0;
        tx_on   = s.ctrl[CTRL_TX_PRESENT];
        ext_on  = s.ctrl[CTRL_EXT_EN];
        n.tick         = 1'b0;
        n.short_strobe = 1'b0;
        n.long_strobe  = 1'b0;
        n.quality_v    = 1'b0;
        n.dp_write     = sel_write;
        n.dp_addr      = haddr[7:0];
        if (sel_read) begin
            n.rdata = rd_word;
        end

        // one-second divider and period boundaries
        if (s.tick_cnt == 25'(TICK_CYCLES_P - 1)) begin
            n.tick_cnt = '0;
            n.tick     = 1'b1;
            if (s.short_sec == 10'(SHORT_SECS_P - 1)) begin
                n.short_sec    = '0;
                n.short_strobe = 1'b1;
            end else begin
                n.short_sec = s.short_sec + 10'h001;
            end
            if (s.sec_cnt == 17'(LONG_SECS_P - 1)) begin
                n.sec_cnt     = '0;
                n.long_strobe = 1'b1;
            end else begin
                n.sec_cnt = s.sec_cnt + 17'h0_0001;
            end
        end else begin
            n.tick_cnt = s.tick_cnt + 25'h000_0001;
        end

        // level tracking within the second; a single sample failing its compare clears that flag
        for (int i = 0; i < 2; i++) begin
            if (!lt_s(received_level, s.rx_thr[i])) n.rx_below[i] = 1'b0;
            if (!lt_s(s.tx_thr[i], eff_tx))         n.tx_above[i] = 1'b0;
        end

        // end of second: count, compare extremes
        if (s.tick) begin
            n.rx_below = 2'b11;
            n.tx_above = 2'b11;
            for (int i = 0; i < 2; i++) begin
                if (s.rx_below[i] && lt_s(received_level, s.rx_thr[i])) begin
                    n.cnt[i]      = sat_inc(s.cnt[i]);
                    n.cnt[8 + i]  = sat_inc(s.cnt[8 + i]);
                    ev[INT_RX_LOW] = 1'b1;
                end
                if (tx_on && s.tx_above[i] && lt_s(s.tx_thr[i], eff_tx)) begin
                    n.cnt[2 + i]  = sat_inc(s.cnt[2 + i]);
                    n.cnt[10 + i] = sat_inc(s.cnt[10 + i]);
                    ev[INT_TX_HI] = 1'b1;
                end
            end
            ev[INT_SECOND] = 1'b1;
            if (ext_on) begin
                if (lt_s(s.rx_peak, received_level))  n.rx_peak  = received_level;
                if (lt_s(received_level, s.rx_floor)) n.rx_floor = received_level;
            end
            if (ext_on && tx_on) begin
                if (lt_s(s.tx_peak, eff_tx))  n.tx_peak  = eff_tx;
                if (lt_s(eff_tx, s.tx_floor)) n.tx_floor = eff_tx;
            end
        end

        // period boundary: reload extremes, move current to history
        // strobe shares its cycle with the closing tick, so history takes the
        // already-incremented count or the last second of the period is lost
        if (s.short_strobe) begin
            n.rx_peak  = received_level;
            n.rx_floor = received_level;
            if (tx_on) begin
                n.tx_peak  = eff_tx;
                n.tx_floor = eff_tx;
            end
            for (int i = 0; i < 4; i++) begin
                n.cnt[4 + i] = n.cnt[i];
                n.cnt[i]     = 16'h0000;
            end
            ev[INT_SHORT] = 1'b1;
            // quality forwarded per period only under type d protection
            n.quality   = s.ctrl[CTRL_PROT_D] ? quality_errors : 16'h0000;
            n.quality_v = s.ctrl[CTRL_PROT_D];
        end
        if (s.long_strobe) begin
            for (int i = 0; i < 4; i++) begin
                n.cnt[12 + i] = n.cnt[8 + i];
                n.cnt[8 + i]  = 16'h0000;
            end
            ev[INT_LONG] = 1'b1;
        end

        // register writes in the data phase
        if (s.dp_write) begin
            case (s.dp_addr)
                OFS_CTRL: n.ctrl = hwdata[7:0];
                OFS_RX_THR: begin
                    n.rx_thr[0] = hwdata[7:0];
                    n.rx_thr[1] = hwdata[15:8];
                    thr_clr[0]  = (hwdata[7:0] != s.rx_thr[0]) || (hwdata[15:8] != s.rx_thr[1]);
                end
                OFS_TX_THR: begin
                    n.tx_thr[0] = hwdata[7:0];
                    n.tx_thr[1] = hwdata[15:8];
                    thr_clr[1]  = (hwdata[7:0] != s.tx_thr[0]) || (hwdata[15:8] != s.tx_thr[1]);
                end
                OFS_INT_ENABLE: n.int_enable = hwdata[INT_BITS-1:0];
                OFS_INT_CLEAR:  clr = hwdata[INT_BITS-1:0];
                default: ;
            endcase
        end
        // optional clear of current counters on threshold change
        if (s.ctrl[CTRL_CLR_ON_THR]) begin
            for (int i = 0; i < 2; i++) begin
                if (thr_clr[0]) begin
                    n.cnt[i]     = 16'h0000;
                    n.cnt[8 + i] = 16'h0000;
                end
                if (thr_clr[1]) begin
                    n.cnt[2 + i]  = 16'h0000;
                    n.cnt[10 + i] = 16'h0000;
                end
            end
        end
        // set beats clear in the same cycle
        n.int_status = (s.int_status & ~clr) | ev;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s           <= '0;
            s.ctrl      <= CTRL_RESET;
            s.rx_thr[0] <= RX_THR0_RESET;
            s.rx_thr[1] <= RX_THR1_RESET;
            s.tx_thr[0] <= TX_THR0_RESET;
            s.tx_thr[1] <= TX_THR1_RESET;
            s.rx_below  <= 2'b11;
            s.tx_above  <= 2'b11;
            s.rx_floor  <= 8'h7F;
            s.rx_peak   <= 8'h80;
            s.tx_floor  <= 8'h7F;
            s.tx_peak   <= 8'h80;
        end else begin
            s <= n;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // only the selected short-period counter leaves towards management
    assign rx_low_level_seconds = s.cnt[{3'h0, s.ctrl[CTRL_RX_SEL]}];
    assign quality_report = s.quality;
    assign quality_valid  = s.quality_v;
    assign second_tick    = s.tick;
    assign hrdata         = s.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign irq            = |(s.int_status & s.int_enable);
endmodule
`default_nettype wire

// File: dv/level_source.sv
// level_source: estimator model driving rx/tx levels and an error count
// assumes the bench sets target levels; they reach the pins one clock later
`timescale 1ns/1ps
`default_nettype none
module level_source (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // requested levels and pacing
    input  wire logic [7:0]  rx_req,
    input  wire logic [7:0]  tx_req,
    input  wire logic        second_tick,
    // estimator outputs
    output logic      [7:0]  received_level,
    output logic      [7:0]  transmitted_level,
    output logic      [15:0] quality_errors
);
    // ****************
    // estimator
    // ****************
    // error count steps once a second, so the report changes between periods
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quality_errors <= 16'h0;
        end else if (second_tick) begin
            quality_errors <= quality_errors + 16'h1;
        end
    end
    // levels follow the request one clock late, already integer dBm
    always_ff @(posedge hclk) begin
        received_level    <= rx_req;
        transmitted_level <= tx_req;
    end
endmodule
`default_nettype wire

// File: dv/level_monitor_sva.sv
// level_monitor_sva: bus and pacing checks on the monitor's ports
// assumes it is bound into every radio_level_performance_monitor instance
`timescale 1ns/1ps
`default_nettype none
module level_monitor_sva #(
    parameter int unsigned TICK_CYCLES_P = 20,
    parameter int unsigned SHORT_SECS_P  = 3
) (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // levels and management side
    input wire logic [7:0]  received_level,
    input wire logic        second_tick,
    input wire logic        quality_valid
);
    import level_monitor_pkg::*;
    // ****************
    // checks
    // ****************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    int unsigned cyc;
    int unsigned secs;
    logic        tick_seen;
    logic        qv_seen;
    logic        rd_ph;
    assign rd_ph = hsel && hready && htrans[1] && !hwrite;
    // first interval after reset is not judged, the divider phase is unknown
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc       <= 32'h0;
            secs      <= 32'h0;
            tick_seen <= 1'b0;
            qv_seen   <= 1'b0;
        end else begin
            cyc       <= second_tick ? 32'h0 : cyc + 32'h1;
            tick_seen <= tick_seen | second_tick;
            qv_seen   <= qv_seen | quality_valid;
            if (quality_valid) begin
                secs <= 32'h0;
            end else if (second_tick) begin
                secs <= secs + 32'h1;
            end
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_tick_space: assert property (second_tick && tick_seen |-> cyc == TICK_CYCLES_P - 1)
        else $error("second tick spacing wrong");
    a_tick_gap: assert property (second_tick |=> !second_tick [*8])
        else $error("second tick too long");
    a_qv_gap: assert property (quality_valid |=> !quality_valid [*8])
        else $error("quality pulse too long");
    a_qv_cadence: assert property (quality_valid && qv_seen |-> secs != 0 && secs % SHORT_SECS_P == 0)
        else $error("quality pulse off period boundary");
    a_rdata_hold: assert property (!rd_ph |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (rd_ph && haddr[7:0] >= 8'h28 && haddr[7:0] <= 8'h3C |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_levels_read: assert property (rd_ph && haddr[7:0] == OFS_LEVELS && $stable(received_level)
        |=> hrdata[7:0] == $past(received_level))
        else $error("received level read wrong");
endmodule
bind radio_level_performance_monitor level_monitor_sva #(.TICK_CYCLES_P(TICK_CYCLES_P), .SHORT_SECS_P(SHORT_SECS_P))
    i_level_monitor_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .received_level(received_level), .second_tick(second_tick), .quality_valid(quality_valid));
`default_nettype wire

// File: dv/radio_level_performance_monitor_tb_top.sv
// radio_level_performance_monitor_tb_top: scenario bench for the level monitor
// assumes shortened counts: 20-cycle second, 3 s and 6 s periods
`timescale 1ns/1ps
`default_nettype none
module radio_level_performance_monitor_tb_top;
    import level_monitor_pkg::*;
    // ****************
    // bench
    // ****************
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        hreadyout, hresp, quality_valid, second_tick, irq;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  rx_req = 8'hB5, tx_req = 8'h20, tx_offset = 8'h0, rxl, txl;
    logic [15:0] low_secs, qerr, qrep;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    int          num_errors = 0, num_checks = 0, cycles = 0, qv_count = 0, n;
    always #25 hclk = ~hclk;
    radio_level_performance_monitor #(.TICK_CYCLES_P(20), .SHORT_SECS_P(3), .LONG_SECS_P(6))
        i_radio_level_performance_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .received_level(rxl),
        .transmitted_level(txl), .tx_offset(tx_offset), .quality_errors(qerr),
        .rx_low_level_seconds(low_secs), .quality_report(qrep), .quality_valid(quality_valid),
        .second_tick(second_tick), .irq(irq));
    level_source i_level_source (.hclk(hclk), .hresetn(hresetn), .rx_req(rx_req), .tx_req(tx_req),
        .second_tick(second_tick), .received_level(rxl), .transmitted_level(txl), .quality_errors(qerr));
    // hang guard well above the few hundred cycles the scenarios need
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (quality_valid === 1'b1) qv_count <= qv_count + 1;
        if (cycles == 4000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // single transfer; master waits for hready however long it takes
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask
    function automatic logic [7:0] ca(input logic [1:0] b, input logic [1:0] k);
        return OFS_CNT_BASE + {2'h0, b, k, 2'h0};
    endfunction
    task automatic ticks(input int k);
        repeat (k) @(posedge hclk iff second_tick === 1'b1);
    endtask
    // align to just after a period boundary via the period interrupt
    task automatic sync();
        wr(OFS_INT_CLEAR, 32'h1F);
        wr(OFS_INT_ENABLE, 32'h2);
        @(posedge hclk iff irq === 1'b1);
    endtask
    task automatic t_reset();
        rdc(OFS_CTRL, {24'h0, CTRL_RESET}, "ctrl");
        rdc(OFS_RX_THR, 32'hBAB0, "rx thr");
        rdc(OFS_TX_THR, 32'h231E, "tx thr");
        wr(8'h30, 32'hFFFFFFFF);
        rdc(8'h30, 32'h0, "unmapped");
        rdc(OFS_LEVELS, 32'h20B5, "levels");
    endtask
    task automatic t_count();
        sync();
        ticks(2);
        rdc(ca(BANK_SHORT_CUR, 2'h0), 32'h0, "rx cnt0");
        rdc(ca(BANK_SHORT_CUR, 2'h1), 32'h2, "rx cnt1");
        rdc(ca(BANK_SHORT_CUR, 2'h2), 32'h2, "tx cnt0");
        rdc(ca(BANK_SHORT_CUR, 2'h3), 32'h0, "tx cnt1");
        chk({16'h0, low_secs}, 32'h0, "forwarded");
        wr(OFS_CTRL, 32'h32);
        repeat (2) @(posedge hclk);
        chk({16'h0, low_secs}, 32'h2, "forwarded");
        ticks(1);
        rdc(ca(BANK_SHORT_HIST, 2'h1), 32'h3, "rx hist");
        rdc(ca(BANK_SHORT_HIST, 2'h2), 32'h3, "tx hist");
        rdc(ca(BANK_SHORT_CUR, 2'h1), 32'h0, "rx cur");
        rdc(ca(BANK_LONG_HIST, 2'h1), 32'h6, "rx day hist");
    endtask
    task automatic t_clear();
        wr(OFS_CTRL, 32'h33);
        ticks(1);
        wr(OFS_RX_THR, 32'hBAB1);
        rdc(ca(BANK_SHORT_CUR, 2'h1), 32'h0, "rx cleared");
        rdc(ca(BANK_SHORT_CUR, 2'h2), 32'h1, "tx kept");
        rdc(OFS_RX_THR, 32'hBAB1, "rx thr");
        wr(OFS_CTRL, 32'h31);
        rdc(ca(BANK_SHORT_CUR, 2'h2), 32'h0, "tx absent");
    endtask
    task automatic t_irq();
        sync();
        bus(1'b0, OFS_INT_STATUS, 32'h0);
        chk({31'h0, rd[INT_SHORT]}, 32'h1, "period status");
        wr(OFS_INT_ENABLE, 32'h0);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(OFS_INT_ENABLE, 32'h2);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(OFS_INT_CLEAR, 32'h2);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
    endtask
    task automatic t_ext();
        wr(OFS_CTRL, 32'h22);
        sync();
        rdc(OFS_RX_EXT, 32'hB5B5, "rx reload");
        rdc(OFS_TX_EXT, 32'h2020, "tx reload");
        rx_req <= 8'hC0;
        tx_req <= 8'h25;
        ticks(1);
        rdc(OFS_RX_EXT, 32'hC0B5, "rx peak");
        rdc(OFS_TX_EXT, 32'h2520, "tx peak");
        rx_req <= 8'hA0;
        tx_req <= 8'h10;
        ticks(1);
        rdc(OFS_RX_EXT, 32'hC0A0, "rx floor");
        rdc(OFS_TX_EXT, 32'h2510, "tx floor");
        tx_offset <= 8'h03;
        wr(OFS_CTRL, 32'h26);
        rdc(OFS_LEVELS, 32'h13A0, "offset levels");
    endtask
    task automatic t_quality();
        chk(qv_count, 32'h0, "quality off");
        chk({16'h0, qrep}, 32'h0, "quality idle");
        sync();
        wr(OFS_CTRL, 32'h2A);
        n = qv_count;
        sync();
        repeat (2) @(posedge hclk);
        chk(qv_count - n, 32'h1, "quality on");
        // report carries the count from the boundary cycle, one model step behind
        chk({16'h0, qrep}, {16'h0, qerr - 16'h1}, "quality report");
        ticks(3);
        repeat (2) @(posedge hclk);
        chk(qv_count - n, 32'h2, "quality next");
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_count();
        t_clear();
        t_irq();
        t_ext();
        t_quality();
        complete_run();
    end
endmodule
`default_nettype wire
